/* File: logic/config_regs_pkg.sv */
// constants shared by the display memory and strap configuration registers
package config_regs_pkg;

  // host i/o ports
  localparam logic [15:0] INDEX_PORT    = 16'h03C4;
  localparam logic [15:0] DATA_PORT     = 16'h03C5;
  localparam logic [15:0] SUBSYS_PORT_A = 16'h46E8;
  localparam logic [15:0] SUBSYS_PORT_B = 16'h03C3;

  // register indices behind the data port
  localparam logic [7:0] IDX_DISPLAY_MEMORY = 8'hCD;
  localparam logic [7:0] IDX_STRAP_ONE      = 8'hCE;
  localparam logic [7:0] IDX_STRAP_TWO      = 8'hCF;

  // reset and fixed values
  localparam logic [7:0] DISPLAY_MEMORY_RESET = 8'h00;
  localparam logic [7:0] STRAP_TWO_VALUE      = 8'hFF;
  localparam logic [7:0] INDEX_RESET          = 8'h00;
  localparam logic [7:0] READ_ZERO            = 8'h00;

  // display memory register fields
  localparam int CFG_LSB        = 0;
  localparam int CFG_MSB        = 1;
  localparam int ASYM_BIT_BASE  = 2; // group g uses bit 2+2g
  localparam int DUALW_BIT_BASE = 3; // group g uses bit 3+2g
  localparam int TWO_MEG_BIT    = 6;
  localparam int BANK_GROUPS    = 2; // group 0 = banks a and b, group 1 = bank c

  // memory configuration codes
  localparam logic [1:0] CFG_AB_32 = 2'h0;
  localparam logic [1:0] CFG_A_16  = 2'h1;
  localparam logic [1:0] CFG_AC_32 = 2'h2;

  // strap register fields
  localparam int STRAP_ROM_ON_PIN = 0;
  localparam int STRAP_BIOS_SMALL = 1;
  localparam int STRAP_BIOS_HIGH  = 2;
  localparam int STRAP_IO8_ONLY   = 3;
  localparam int STRAP_SUBSYS_3C3 = 4;
  localparam int STRAP_START_OFF  = 5;
  localparam int STRAP_BUS_16     = 6;
  localparam int STRAP_ALE_LATCH  = 7;

  // bios windows, compared on address bits 19:16
  localparam logic [3:0] BIOS_SEG_C = 4'hC;
  localparam logic [3:0] BIOS_SEG_E = 4'hE;

  // display memory address limits
  localparam logic [20:0] LIMIT_ONE_MEG = 21'h0F_FFFF;
  localparam logic [20:0] LIMIT_TWO_MEG = 21'h1F_FFFF;

endpackage

/* File: logic/strap_capture.sv */
// strap capture: samples the strap pins while power-on reset is held
module strap_capture
  import config_regs_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire logic [7:0] strap_pin_in,
  output logic      [7:0] strap_out
);

  // tracks the pins through reset, then freezes; unloaded pins read one via the pad pull-ups
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      strap_out <= strap_pin_in;
    end
  end

endmodule

/* File: logic/bios_rom_decode.sv */
// bios rom window decode and chip select routing onto the shared power pin
module bios_rom_decode
  import config_regs_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic [7:0]  strap_in,
  input  wire logic        direct_local_bus_in,
  input  wire logic [19:0] mem_addr_in,
  input  wire logic        mem_cycle_in,
  input  wire logic        power_ctrl_in,
  output logic             bios_hit_out,
  output logic             bios_rom_select_n_out,
  output logic             multiplexed_power_pin_out
);

  logic [3:0] bios_segment;
  logic       rom_on_pin;

  // small window picks a relocatable segment, the full window is always segment c
  always_comb
  begin
    if (!strap_in[STRAP_BIOS_SMALL])
    begin
      bios_segment = BIOS_SEG_C;
    end
    else
    begin
      bios_segment = strap_in[STRAP_BIOS_HIGH] ? BIOS_SEG_C : BIOS_SEG_E;
    end
  end

  assign rom_on_pin   = direct_local_bus_in & strap_in[STRAP_ROM_ON_PIN];
  assign bios_hit_out = mem_cycle_in & (mem_addr_in[19:16] == bios_segment);

  // registered so the select pin never glitches on address decode
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      bios_rom_select_n_out     <= 1'b1;
      multiplexed_power_pin_out <= 1'b0;
    end
    else
    begin
      bios_rom_select_n_out     <= ~bios_hit_out;
      multiplexed_power_pin_out <= rom_on_pin ? ~bios_hit_out : power_ctrl_in;
    end
  end

endmodule

/* File: logic/memory_and_strap_config_regs.sv */
// display memory and strap configuration registers behind the indexed sequencer port
module memory_and_strap_config_regs
  import config_regs_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic [15:0] io_addr_in,
  input  wire logic        io_write_in,
  input  wire logic        io_read_in,
  input  wire logic [7:0]  io_wdata_in,
  input  wire logic [7:0]  strap_pin_in,
  input  wire logic        direct_local_bus_in,
  input  wire logic [19:0] mem_addr_in,
  input  wire logic        mem_cycle_in,
  input  wire logic        power_ctrl_in,
  output logic             io_hit_out,
  output logic      [7:0]  io_rdata_out,
  output logic             bank_a_enable_out,
  output logic             bank_b_enable_out,
  output logic             bank_c_enable_out,
  output logic             bus_32bit_out,
  output logic             bank_c_display_out,
  output logic      [1:0]  asym_addr_out,
  output logic      [1:0]  dual_write_out,
  output logic             mem_2mb_out,
  output logic             counter_extend_out,
  output logic      [20:0] display_addr_limit_out,
  output logic             bios_hit_out,
  output logic             bios_rom_select_n_out,
  output logic             multiplexed_power_pin_out,
  output logic             io16_enable_out,
  output logic      [15:0] subsys_port_out,
  output logic             subsys_enable_out,
  output logic             host_bus_16bit_out,
  output logic             ale_latch_mode_out
);

  logic [7:0]  index_reg;
  logic [7:0]  display_memory_config;
  logic [7:0]  strap_config_one;
  logic [7:0]  next_rdata;
  logic        hit_index;
  logic        hit_data;
  logic        hit_subsys;
  logic        start_pending;
  logic [1:0]  cfg_field;
  logic [1:0]  next_asym;
  logic [1:0]  next_dual_write;

  // port compare used for every decoded port
  function automatic logic port_match(input logic [15:0] addr, input logic [15:0] port);
    return addr == port;
  endfunction

  /////////////////////////////////////////////////////////////////////////////
  // submodules

  strap_capture u_strap_capture (
    .clock_in     (clock_in),
    .reset_in     (reset_in),
    .strap_pin_in (strap_pin_in),
    .strap_out    (strap_config_one)
  );

  bios_rom_decode u_bios_rom_decode (
    .clock_in                  (clock_in),
    .reset_in                  (reset_in),
    .strap_in                  (strap_config_one),
    .direct_local_bus_in       (direct_local_bus_in),
    .mem_addr_in               (mem_addr_in),
    .mem_cycle_in              (mem_cycle_in),
    .power_ctrl_in             (power_ctrl_in),
    .bios_hit_out              (bios_hit_out),
    .bios_rom_select_n_out     (bios_rom_select_n_out),
    .multiplexed_power_pin_out (multiplexed_power_pin_out)
  );

  /////////////////////////////////////////////////////////////////////////////
  // host port decode

  // subsystem enable port moves with the strap
  assign subsys_port_out = strap_config_one[STRAP_SUBSYS_3C3] ? SUBSYS_PORT_B : SUBSYS_PORT_A;
  assign hit_index  = port_match(io_addr_in, INDEX_PORT);
  assign hit_data   = port_match(io_addr_in, DATA_PORT);
  assign hit_subsys = port_match(io_addr_in, subsys_port_out);
  assign io_hit_out = (io_read_in | io_write_in) & (hit_index | hit_data | hit_subsys);

  // index register selects which register the data port reaches
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      index_reg <= INDEX_RESET;
    end
    else if (io_write_in && hit_index)
    begin
      index_reg <= io_wdata_in;
    end
  end

  // only the display memory index is writable; strap writes fall through untouched
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      display_memory_config <= DISPLAY_MEMORY_RESET;
    end
    else if (io_write_in && hit_data && index_reg == IDX_DISPLAY_MEMORY)
    begin
      display_memory_config <= io_wdata_in;
    end
  end

  // read mux; unmapped indices read zero
  always_comb
  begin
    next_rdata = READ_ZERO;
    if (hit_index)
    begin
      next_rdata = index_reg;
    end
    else if (hit_subsys)
    begin
      next_rdata = {7'h00, subsys_enable_out};
    end
    else if (hit_data)
    begin
      case (index_reg)
        IDX_DISPLAY_MEMORY: next_rdata = display_memory_config;
        IDX_STRAP_ONE:      next_rdata = strap_config_one;
        IDX_STRAP_TWO:      next_rdata = STRAP_TWO_VALUE;
        default:            next_rdata = READ_ZERO;
      endcase
    end
  end

  // read data holds until the next read
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      io_rdata_out <= READ_ZERO;
    end
    else if (io_read_in)
    begin
      io_rdata_out <= next_rdata;
    end
  end

  /////////////////////////////////////////////////////////////////////////////
  // subsystem enable

  // the strap is only stable once reset has gone, so the start state loads one cycle later
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      start_pending     <= 1'b1;
      subsys_enable_out <= 1'b0;
    end
    else if (start_pending)
    begin
      start_pending     <= 1'b0;
      subsys_enable_out <= ~strap_config_one[STRAP_START_OFF];
    end
    else if (io_write_in && hit_subsys)
    begin
      subsys_enable_out <= io_wdata_in[0];
    end
  end

  /////////////////////////////////////////////////////////////////////////////
  // memory interface decode

  assign cfg_field = display_memory_config[CFG_MSB:CFG_LSB];

  // per bank group addressing and strobe style
  genvar g;
  generate
    for (g = 0; g < BANK_GROUPS; g++)
    begin : g_bank_group
      assign next_asym[g]       = display_memory_config[ASYM_BIT_BASE + 2 * g];
      assign next_dual_write[g] = display_memory_config[DUALW_BIT_BASE + 2 * g];
    end
  endgenerate

  // reserved code falls back to the narrow bank a setup, the safest for any fitted memory
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      bank_a_enable_out  <= 1'b1;
      bank_b_enable_out  <= 1'b1;
      bank_c_enable_out  <= 1'b0;
      bus_32bit_out      <= 1'b1;
      bank_c_display_out <= 1'b0;
    end
    else
    begin
      bank_a_enable_out  <= 1'b1;
      bank_b_enable_out  <= (cfg_field == CFG_AB_32);
      bank_c_enable_out  <= (cfg_field == CFG_AC_32);
      bus_32bit_out      <= (cfg_field == CFG_AB_32) || (cfg_field == CFG_AC_32);
      bank_c_display_out <= (cfg_field == CFG_AC_32);
    end
  end

  // styles and memory size
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      asym_addr_out          <= 2'h0;
      dual_write_out         <= 2'h0;
      mem_2mb_out            <= 1'b0;
      counter_extend_out     <= 1'b0;
      display_addr_limit_out <= LIMIT_ONE_MEG;
    end
    else
    begin
      asym_addr_out          <= next_asym;
      dual_write_out         <= next_dual_write;
      mem_2mb_out            <= display_memory_config[TWO_MEG_BIT];
      counter_extend_out     <= display_memory_config[TWO_MEG_BIT];
      display_addr_limit_out <= display_memory_config[TWO_MEG_BIT] ? LIMIT_TWO_MEG : LIMIT_ONE_MEG;
    end
  end

  /////////////////////////////////////////////////////////////////////////////
  // host bus straps

  assign io16_enable_out    = ~strap_config_one[STRAP_IO8_ONLY];
  assign host_bus_16bit_out = strap_config_one[STRAP_BUS_16];
  assign ale_latch_mode_out = strap_config_one[STRAP_ALE_LATCH];

  /////////////////////////////////////////////////////////////////////////////
  // checks

  a_reset_clears_cfg: assert property (@(posedge clock_in)
    reset_in |=> display_memory_config == DISPLAY_MEMORY_RESET)
    else $error("display memory register not cleared by reset");

  a_cfg_write_read: assert property (@(posedge clock_in) disable iff (reset_in)
    io_write_in && hit_data && index_reg == IDX_DISPLAY_MEMORY ##1 io_read_in && hit_data && !io_write_in
    |=> io_rdata_out == $past(io_wdata_in, 2))
    else $error("display memory register did not read back written value");

  a_strap_write_ignored: assert property (@(posedge clock_in) disable iff (reset_in)
    io_write_in && hit_data && index_reg != IDX_DISPLAY_MEMORY
    |=> $stable(display_memory_config) && $stable(strap_config_one))
    else $error("write to read only strap register changed state");

  a_strap_held: assert property (@(posedge clock_in) disable iff (reset_in)
    !$past(reset_in) |-> $stable(strap_config_one))
    else $error("strap value changed outside power-on reset");

  a_bank_select: assert property (@(posedge clock_in) disable iff (reset_in)
    cfg_field == CFG_A_16 |=> !bank_b_enable_out && !bank_c_enable_out && !bus_32bit_out)
    else $error("16-bit setting left a second bank enabled");

  a_bank_c_display: assert property (@(posedge clock_in) disable iff (reset_in)
    cfg_field == CFG_AC_32 |=> bank_c_display_out && bank_c_enable_out && !bank_b_enable_out)
    else $error("bank c not used as display memory");

  a_two_meg_limit: assert property (@(posedge clock_in) disable iff (reset_in)
    display_memory_config[TWO_MEG_BIT]
    |=> mem_2mb_out && counter_extend_out && display_addr_limit_out == LIMIT_TWO_MEG)
    else $error("2 MB mode without widened address range");

  a_group_styles: assert property (@(posedge clock_in) disable iff (reset_in)
    1'b1 |=> asym_addr_out[1] == $past(display_memory_config[ASYM_BIT_BASE + 2]))
    else $error("bank c addressing style does not follow register");

  a_start_state: assert property (@(posedge clock_in)
    $fell(reset_in) |=> subsys_enable_out == !strap_config_one[STRAP_START_OFF])
    else $error("start state does not follow strap");

  a_subsys_port: assert property (@(posedge clock_in) disable iff (reset_in)
    strap_config_one[STRAP_SUBSYS_3C3] |-> subsys_port_out == SUBSYS_PORT_B)
    else $error("subsystem enable port not relocated");

  a_host_width: assert property (@(posedge clock_in) disable iff (reset_in)
    host_bus_16bit_out == strap_config_one[STRAP_BUS_16] && io16_enable_out != strap_config_one[STRAP_IO8_ONLY])
    else $error("host width outputs disagree with straps");

  a_rom_pin: assert property (@(posedge clock_in) disable iff (reset_in)
    direct_local_bus_in && strap_config_one[STRAP_ROM_ON_PIN] && bios_hit_out |=> !multiplexed_power_pin_out)
    else $error("bios select not routed to power pin");

endmodule

/* File: verification/memory_and_strap_config_regs_tb.sv */
// self-checking bench for the display memory and strap configuration registers
module memory_and_strap_config_regs_tb
  import config_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    int          sel;
    logic [20:0] exp;
  } note_t;

  logic        clock_in            = 1'b0;
  logic        reset_in            = 1'b1;
  logic [15:0] io_addr_in          = 16'h0000;
  logic        io_write_in         = 1'b0;
  logic        io_read_in          = 1'b0;
  logic [7:0]  io_wdata_in         = 8'h00;
  logic [7:0]  strap_pin_in        = 8'hFF;
  logic        direct_local_bus_in = 1'b0;
  logic [19:0] mem_addr_in         = 20'h0_0000;
  logic        mem_cycle_in        = 1'b0;
  logic        power_ctrl_in       = 1'b0;
  logic        io_hit_out;
  logic [7:0]  io_rdata_out;
  logic        bank_a_enable_out;
  logic        bank_b_enable_out;
  logic        bank_c_enable_out;
  logic        bus_32bit_out;
  logic        bank_c_display_out;
  logic [1:0]  asym_addr_out;
  logic [1:0]  dual_write_out;
  logic        mem_2mb_out;
  logic        counter_extend_out;
  logic [20:0] display_addr_limit_out;
  logic        bios_hit_out;
  logic        bios_rom_select_n_out;
  logic        multiplexed_power_pin_out;
  logic        io16_enable_out;
  logic [15:0] subsys_port_out;
  logic        subsys_enable_out;
  logic        host_bus_16bit_out;
  logic        ale_latch_mode_out;

  note_t       notes[$];
  note_t       nt;
  int          n_mismatch  = 0;
  int          checks_done = 0;
  logic [7:0]  strap;
  logic [7:0]  v;
  logic [3:0]  seg;
  logic [3:0]  tgt;
  logic        hit;
  logic        cyc;
  logic [15:0] sport;
  string       names[14] = '{"io_rdata", "bank_flags", "style_bits", "two_meg", "addr_limit", "io16",
                             "subsys_port", "subsys_enable", "host_bus_16", "ale_latch", "rom_select_n",
                             "power_pin", "bios_hit", "io_hit"};

  ////////////////////////////////////////////////////////////////////////////////
  // clock, design instance
  always #2 clock_in = ~clock_in;

  memory_and_strap_config_regs i_memory_and_strap_config_regs (
    .clock_in                  (clock_in),
    .reset_in                  (reset_in),
    .io_addr_in                (io_addr_in),
    .io_write_in               (io_write_in),
    .io_read_in                (io_read_in),
    .io_wdata_in               (io_wdata_in),
    .strap_pin_in              (strap_pin_in),
    .direct_local_bus_in       (direct_local_bus_in),
    .mem_addr_in               (mem_addr_in),
    .mem_cycle_in              (mem_cycle_in),
    .power_ctrl_in             (power_ctrl_in),
    .io_hit_out                (io_hit_out),
    .io_rdata_out              (io_rdata_out),
    .bank_a_enable_out         (bank_a_enable_out),
    .bank_b_enable_out         (bank_b_enable_out),
    .bank_c_enable_out         (bank_c_enable_out),
    .bus_32bit_out             (bus_32bit_out),
    .bank_c_display_out        (bank_c_display_out),
    .asym_addr_out             (asym_addr_out),
    .dual_write_out            (dual_write_out),
    .mem_2mb_out               (mem_2mb_out),
    .counter_extend_out        (counter_extend_out),
    .display_addr_limit_out    (display_addr_limit_out),
    .bios_hit_out              (bios_hit_out),
    .bios_rom_select_n_out     (bios_rom_select_n_out),
    .multiplexed_power_pin_out (multiplexed_power_pin_out),
    .io16_enable_out           (io16_enable_out),
    .subsys_port_out           (subsys_port_out),
    .subsys_enable_out         (subsys_enable_out),
    .host_bus_16bit_out        (host_bus_16bit_out),
    .ale_latch_mode_out        (ale_latch_mode_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // helpers: output selection, comparison, bus cycles
  function automatic logic [20:0] seen(int sel);
    case (sel)
      0:       return {13'h0, io_rdata_out};
      1:       return {16'h0, bank_a_enable_out, bank_b_enable_out, bank_c_enable_out, bus_32bit_out,
                       bank_c_display_out};
      2:       return {17'h0, asym_addr_out[1], asym_addr_out[0], dual_write_out[1], dual_write_out[0]};
      3:       return {19'h0, mem_2mb_out, counter_extend_out};
      4:       return display_addr_limit_out;
      5:       return {20'h0, io16_enable_out};
      6:       return {5'h0, subsys_port_out};
      7:       return {20'h0, subsys_enable_out};
      8:       return {20'h0, host_bus_16bit_out};
      9:       return {20'h0, ale_latch_mode_out};
      10:      return {20'h0, bios_rom_select_n_out};
      11:      return {20'h0, multiplexed_power_pin_out};
      12:      return {20'h0, bios_hit_out};
      default: return {20'h0, io_hit_out};
    endcase
  endfunction

  // bank flags {a, b, c, 32-bit, c as display}; reserved code behaves like the 16-bit one
  function automatic logic [20:0] bank_exp(logic [1:0] code);
    case (code)
      2'h0:    return 21'h00_001A;
      2'h2:    return 21'h00_0017;
      default: return 21'h00_0010;
    endcase
  endfunction

  task automatic check(string what, logic [20:0] got, logic [20:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // a note is pushed at a falling edge and judged just after the next rising edge
  task automatic expect_out(int sel, logic [20:0] exp);
    notes.push_back('{sel, exp});
  endtask

  // strobes change only at falling edges, so the rising edge always sees them settled
  task automatic drive(logic wr, logic rd, logic [15:0] addr, logic [7:0] data);
    @(negedge clock_in);
    io_write_in = wr;
    io_read_in  = rd;
    io_addr_in  = addr;
    io_wdata_in = data;
  endtask

  task automatic idle(int n);
    repeat (n) drive(1'b0, 1'b0, 16'h0000, 8'h00);
  endtask

  task automatic wr_reg(logic [7:0] idx, logic [7:0] val);
    drive(1'b1, 1'b0, INDEX_PORT, idx);
    drive(1'b1, 1'b0, DATA_PORT, val);
  endtask

  task automatic rd_reg(logic [7:0] idx, logic [7:0] exp);
    drive(1'b1, 1'b0, INDEX_PORT, idx);
    drive(1'b0, 1'b1, DATA_PORT, 8'h00);
    expect_out(0, {13'h0, exp});
    expect_out(13, 21'h00_0001);
  endtask

  task automatic report_and_stop();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: takes every note due at this edge and compares it
  always @(posedge clock_in)
  begin
    if (notes.size() > 0)
    begin
      #1;
      while (notes.size() > 0)
      begin
        nt = notes.pop_front();
        check(names[nt.sel], seen(nt.sel), nt.exp);
      end
    end
  end

  // watchdog: the whole run needs well under a thousand cycles
  initial
  begin
    #240000;
    n_mismatch++;
    $display("unexpected watchdog: expected end of tests, seen timeout");
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: two power-on rounds, unloaded straps first, random straps second
  initial
  begin
    void'($urandom(32'hf574));
    for (int round = 0; round < 2; round++)
    begin
      strap = (round == 0) ? 8'hFF : 8'($urandom);
      reset_in = 1'b1;
      strap_pin_in = strap;
      idle(20);
      reset_in = 1'b0;
      expect_out(7, {20'h0, ~strap[5]});
      idle(1);
      // pins move after reset; the latched copy must not follow them
      strap_pin_in = ~strap;
      rd_reg(IDX_DISPLAY_MEMORY, 8'h00);
      rd_reg(IDX_STRAP_ONE, strap);
      wr_reg(IDX_STRAP_ONE, ~strap);
      wr_reg(IDX_STRAP_TWO, 8'h00);
      rd_reg(IDX_STRAP_ONE, strap);
      rd_reg(IDX_STRAP_TWO, 8'hFF);
      rd_reg(8'hD5, 8'h00);
      idle(1);
      expect_out(13, 21'h00_0000);
      expect_out(5, {20'h0, ~strap[3]});
      sport = strap[4] ? 16'h03C3 : 16'h46E8;
      expect_out(6, {5'h0, sport});
      expect_out(8, {20'h0, strap[6]});
      expect_out(9, {20'h0, strap[7]});
      // subsystem enable through the selected port: set, then clear
      for (int b = 0; b < 2; b++)
      begin
        drive(1'b1, 1'b0, sport, {7'h0, b == 0});
        drive(1'b0, 1'b1, sport, 8'h00);
        expect_out(0, {20'h0, b == 0});
        expect_out(7, {20'h0, b == 0});
      end
      // every configuration code, with random style and size bits
      for (int i = 0; i < 8; i++)
      begin
        v = {1'b0, 7'($urandom)};
        v[1:0] = 2'(i);
        wr_reg(IDX_DISPLAY_MEMORY, v);
        // read straight after the data write, with the index left in place
        drive(1'b0, 1'b1, DATA_PORT, 8'h00);
        expect_out(0, {13'h0, v});
        idle(2);
        expect_out(1, bank_exp(v[1:0]));
        expect_out(2, {17'h0, v[4], v[2], v[5], v[3]});
        expect_out(3, {19'h0, v[6], v[6]});
        expect_out(4, v[6] ? 21'h1F_FFFF : 21'h0F_FFFF);
        rd_reg(IDX_DISPLAY_MEMORY, v);
      end
      idle(1);
      // bios window: target segment on even steps, random segment on odd ones
      tgt = strap[1] ? (strap[2] ? 4'hC : 4'hE) : 4'hC;
      for (int i = 0; i < 8; i++)
      begin
        seg = i[0] ? 4'($urandom) : tgt;
        cyc = (i % 4) != 3;
        hit = cyc && (seg == tgt);
        @(negedge clock_in);
        mem_addr_in = {seg, 16'($urandom)};
        mem_cycle_in = cyc;
        direct_local_bus_in = 1'($urandom);
        power_ctrl_in = 1'($urandom);
        expect_out(12, {20'h0, hit});
        @(negedge clock_in);
        expect_out(10, {20'h0, ~hit});
        expect_out(11, {20'h0, (direct_local_bus_in & strap[0]) ? ~hit : power_ctrl_in});
      end
      idle(2);
    end
    report_and_stop();
  end

endmodule
